// file: logic/ssru_pkg.sv
package ssru_pkg;

	// ==========================================================
	// operand geometry
	localparam int          WORD_W      = 16;
	localparam int          DWORD_W     = 32;
	localparam int          AMT_W       = 6;
	localparam logic [15:0] WORD_MOD    = 16'h0010;
	localparam logic [15:0] WORD_C_MOD  = 16'h0011;
	localparam logic [15:0] DWORD_MOD   = 16'h0020;
	localparam logic [15:0] DWORD_C_MOD = 16'h0021;
	localparam logic [15:0] COUNT_ONE   = 16'h0001;

	// ==========================================================
	// values after reset
	localparam logic [15:0] DEST_RST    = 16'h0000;
	localparam logic        CARRY_RST   = 1'b0;
	localparam logic        DONE_RST    = 1'b0;

	// ==========================================================
	// operation codes
	typedef enum logic [3:0] {
		WORD_ROTATE_RIGHT          = 4'h0,
		WORD_ROTATE_LEFT           = 4'h1,
		WORD_CARRY_ROTATE_RIGHT    = 4'h2,
		WORD_CARRY_ROTATE_LEFT     = 4'h3,
		DOUBLE_ROTATE_RIGHT        = 4'h4,
		DOUBLE_ROTATE_LEFT         = 4'h5,
		DOUBLE_CARRY_ROTATE_RIGHT  = 4'h6,
		DOUBLE_CARRY_ROTATE_LEFT   = 4'h7,
		WORD_LOGICAL_RIGHT_SHIFT   = 4'h8,
		WORD_LOGICAL_LEFT_SHIFT    = 4'h9,
		DOUBLE_LOGICAL_RIGHT_SHIFT = 4'ha,
		DOUBLE_LOGICAL_LEFT_SHIFT  = 4'hb
	} ssru_op_e;

endpackage

// file: logic/ssru_ring_if.sv
`timescale 1ns/1ps

// ==========================================================
// one rotator ring: operand, reduced amount, direction, result
interface ssru_ring_if #(
	parameter int W = 16
);
	logic [W-1:0]             ring_in;
	logic [W-1:0]             ring_out;
	logic [ssru_pkg::AMT_W-1:0] amount;
	logic                     left;

	modport user (
		output ring_in,
		output amount,
		output left,
		input  ring_out
	);

	modport rot (
		input  ring_in,
		input  amount,
		input  left,
		output ring_out
	);
endinterface

// file: logic/ssru_ring_rot.sv
`timescale 1ns/1ps

// ==========================================================
// barrel rotator over a ring of any width
module ssru_ring_rot (
	// ring
	ssru_ring_if.rot r
);
	localparam int W = $bits(r.ring_in);

	logic [2*W-1:0] dbl;
	logic [2*W-1:0] moved;

	// amount must already be below W; the caller reduces it
	always_comb begin
		dbl = {r.ring_in, r.ring_in};
		if (r.left) begin
			moved      = dbl << r.amount;
			r.ring_out = moved[2*W-1:W];
		end else begin
			moved      = dbl >> r.amount;
			r.ring_out = moved[W-1:0];
		end
	end
endmodule

// file: logic/ssru_top.sv
`timescale 1ns/1ps

// Summary of operation
// - operation acts only while enable is high
// - word carry rotate right over 17-bit ring
// - word carry rotate left over 17-bit ring
// - double rotate right, carry gets last bit
// - double rotate left, carry gets result lsb
// - double carry rotate right over 33-bit ring
// - double carry rotate left over 33-bit ring
// - word shift right, zero fill high
// - word shift left, zero fill low
// - double shift right, zero fill high
// - word rotate right, carry gets last bit
// - word rotate left, carry gets result lsb
// - double shift left, zero fill low
module ssru_top (
	// clock and reset
	input  logic                sys_clk_i,
	input  logic                rstn_i,
	// instruction
	input  logic                enable_i,
	input  ssru_pkg::ssru_op_e  op_i,
	input  logic [15:0]         source_value_lo_i,
	input  logic [15:0]         source_value_hi_i,
	input  logic [15:0]         shift_count_i,
	// results
	output logic [15:0]         dest_lo_o,
	output logic [15:0]         dest_hi_o,
	output logic                carry_flag_o,
	output logic                done_o
);

	// ==========================================================
	// operand forming
	logic [31:0] src_dword;
	logic        count_nz;
	logic [15:0] next_dest_lo;
	logic [15:0] next_dest_hi;
	logic        next_carry;

	assign src_dword = {source_value_hi_i, source_value_lo_i};
	// the count is taken as unsigned; a negative count is the program's fault
	assign count_nz  = |shift_count_i;

	// ==========================================================
	// rotator rings
	ssru_ring_if #(.W(16)) ring_w  ();
	ssru_ring_if #(.W(17)) ring_wc ();
	ssru_ring_if #(.W(32)) ring_d  ();
	ssru_ring_if #(.W(33)) ring_dc ();

	ssru_ring_rot u_rot_w  (.r(ring_w));
	ssru_ring_rot u_rot_wc (.r(ring_wc));
	ssru_ring_rot u_rot_d  (.r(ring_d));
	ssru_ring_rot u_rot_dc (.r(ring_dc));

	// modulo reduction keeps each rotator small at the cost of a divider per ring
	always_comb begin
		ring_w.ring_in  = source_value_lo_i;
		ring_w.amount   = ssru_pkg::AMT_W'(shift_count_i % ssru_pkg::WORD_MOD);
		ring_w.left     = (op_i == ssru_pkg::WORD_ROTATE_LEFT);
		ring_wc.ring_in = {carry_flag_o, source_value_lo_i};
		ring_wc.amount  = ssru_pkg::AMT_W'(shift_count_i % ssru_pkg::WORD_C_MOD);
		ring_wc.left    = (op_i == ssru_pkg::WORD_CARRY_ROTATE_LEFT);
		ring_d.ring_in  = src_dword;
		ring_d.amount   = ssru_pkg::AMT_W'(shift_count_i % ssru_pkg::DWORD_MOD);
		ring_d.left     = (op_i == ssru_pkg::DOUBLE_ROTATE_LEFT);
		ring_dc.ring_in = {carry_flag_o, src_dword};
		ring_dc.amount  = ssru_pkg::AMT_W'(shift_count_i % ssru_pkg::DWORD_C_MOD);
		ring_dc.left    = (op_i == ssru_pkg::DOUBLE_CARRY_ROTATE_LEFT);
	end

	// ==========================================================
	// result selection
	logic [31:0] dshift;

	always_comb begin
		next_dest_lo = dest_lo_o;
		next_dest_hi = dest_hi_o;
		next_carry   = carry_flag_o;
		dshift       = 32'h0000_0000;
		unique case (op_i)
			ssru_pkg::WORD_ROTATE_RIGHT: begin
				next_dest_lo = ring_w.ring_out;
				if (count_nz) begin
					next_carry = ring_w.ring_out[15];
				end
			end
			ssru_pkg::WORD_ROTATE_LEFT: begin
				next_dest_lo = ring_w.ring_out;
				if (count_nz) begin
					next_carry = ring_w.ring_out[0];
				end
			end
			ssru_pkg::WORD_CARRY_ROTATE_RIGHT,
			ssru_pkg::WORD_CARRY_ROTATE_LEFT: begin
				next_dest_lo = ring_wc.ring_out[15:0];
				next_carry   = ring_wc.ring_out[16];
			end
			ssru_pkg::DOUBLE_ROTATE_RIGHT: begin
				{next_dest_hi, next_dest_lo} = ring_d.ring_out;
				if (count_nz) begin
					next_carry = ring_d.ring_out[31];
				end
			end
			ssru_pkg::DOUBLE_ROTATE_LEFT: begin
				{next_dest_hi, next_dest_lo} = ring_d.ring_out;
				if (count_nz) begin
					next_carry = ring_d.ring_out[0];
				end
			end
			ssru_pkg::DOUBLE_CARRY_ROTATE_RIGHT,
			ssru_pkg::DOUBLE_CARRY_ROTATE_LEFT: begin
				{next_dest_hi, next_dest_lo} = ring_dc.ring_out[31:0];
				next_carry                   = ring_dc.ring_out[32];
			end
			ssru_pkg::WORD_LOGICAL_RIGHT_SHIFT: begin
				next_dest_lo = (shift_count_i >= ssru_pkg::WORD_MOD) ? ssru_pkg::DEST_RST
				             : source_value_lo_i >> shift_count_i;
			end
			ssru_pkg::WORD_LOGICAL_LEFT_SHIFT: begin
				next_dest_lo = (shift_count_i >= ssru_pkg::WORD_MOD) ? ssru_pkg::DEST_RST
				             : source_value_lo_i << shift_count_i;
			end
			ssru_pkg::DOUBLE_LOGICAL_RIGHT_SHIFT: begin
				dshift = (shift_count_i >= ssru_pkg::DWORD_MOD) ? 32'h0000_0000
				       : src_dword >> shift_count_i;
				{next_dest_hi, next_dest_lo} = dshift;
			end
			ssru_pkg::DOUBLE_LOGICAL_LEFT_SHIFT: begin
				dshift = (shift_count_i >= ssru_pkg::DWORD_MOD) ? 32'h0000_0000
				       : src_dword << shift_count_i;
				{next_dest_hi, next_dest_lo} = dshift;
			end
			// unused codes change nothing
			default: begin
				next_dest_lo = dest_lo_o;
			end
		endcase
	end

	// ==========================================================
	// destination and flag registers
	// destination and carry write only when enabled; done is written every cycle
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			dest_lo_o <= ssru_pkg::DEST_RST;
			dest_hi_o <= ssru_pkg::DEST_RST;
		end else if (enable_i) begin
			dest_lo_o <= next_dest_lo;
			dest_hi_o <= next_dest_hi;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			carry_flag_o <= ssru_pkg::CARRY_RST;
		end else if (enable_i) begin
			carry_flag_o <= next_carry;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			done_o <= ssru_pkg::DONE_RST;
		end else begin
			done_o <= enable_i;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);

	a_idle_hold: assert property (
		!enable_i |=> $stable(dest_lo_o) && $stable(dest_hi_o) && $stable(carry_flag_o) && !done_o
	) else $error("state changed while idle");

	a_done_follows: assert property (
		enable_i |=> done_o
	) else $error("no completion after enabled operation");

	a_wcr_right: assert property (
		enable_i && op_i == ssru_pkg::WORD_CARRY_ROTATE_RIGHT && shift_count_i == ssru_pkg::COUNT_ONE
		|=> dest_lo_o == {$past(carry_flag_o), $past(source_value_lo_i[15:1])}
		    && carry_flag_o == $past(source_value_lo_i[0])
	) else $error("word carry rotate right wrong");

	a_wcr_left: assert property (
		enable_i && op_i == ssru_pkg::WORD_CARRY_ROTATE_LEFT && shift_count_i == ssru_pkg::COUNT_ONE
		|=> dest_lo_o == {$past(source_value_lo_i[14:0]), $past(carry_flag_o)}
		    && carry_flag_o == $past(source_value_lo_i[15])
	) else $error("word carry rotate left wrong");

	a_drot_right: assert property (
		enable_i && op_i == ssru_pkg::DOUBLE_ROTATE_RIGHT && shift_count_i == ssru_pkg::COUNT_ONE
		|=> {dest_hi_o, dest_lo_o} == {$past(source_value_lo_i[0]), $past(src_dword[31:1])}
		    && carry_flag_o == dest_hi_o[15]
	) else $error("double rotate right wrong");

	a_drot_left: assert property (
		enable_i && op_i == ssru_pkg::DOUBLE_ROTATE_LEFT && shift_count_i != 16'h0000
		|=> carry_flag_o == dest_lo_o[0]
	) else $error("double rotate left carry wrong");

	a_dcr_right: assert property (
		enable_i && op_i == ssru_pkg::DOUBLE_CARRY_ROTATE_RIGHT && shift_count_i == ssru_pkg::COUNT_ONE
		|=> {dest_hi_o, dest_lo_o} == {$past(carry_flag_o), $past(src_dword[31:1])}
		    && carry_flag_o == $past(source_value_lo_i[0])
	) else $error("double carry rotate right wrong");

	a_dcr_left: assert property (
		enable_i && op_i == ssru_pkg::DOUBLE_CARRY_ROTATE_LEFT && shift_count_i == ssru_pkg::COUNT_ONE
		|=> {dest_hi_o, dest_lo_o} == {$past(src_dword[30:0]), $past(carry_flag_o)}
		    && carry_flag_o == $past(source_value_hi_i[15])
	) else $error("double carry rotate left wrong");

	a_wsh_right: assert property (
		enable_i && op_i == ssru_pkg::WORD_LOGICAL_RIGHT_SHIFT
		|=> dest_lo_o == ($past(source_value_lo_i) >> $past(shift_count_i)) && $stable(carry_flag_o)
	) else $error("word shift right wrong");

	a_wsh_left: assert property (
		enable_i && op_i == ssru_pkg::WORD_LOGICAL_LEFT_SHIFT
		|=> dest_lo_o == 16'($past(source_value_lo_i) << $past(shift_count_i)) && $stable(dest_hi_o)
	) else $error("word shift left wrong");

	a_dsh_right: assert property (
		enable_i && op_i == ssru_pkg::DOUBLE_LOGICAL_RIGHT_SHIFT
		|=> {dest_hi_o, dest_lo_o} == ($past(src_dword) >> $past(shift_count_i))
	) else $error("double shift right wrong");

	a_dsh_left: assert property (
		enable_i && op_i == ssru_pkg::DOUBLE_LOGICAL_LEFT_SHIFT
		|=> {dest_hi_o, dest_lo_o} == 32'($past(src_dword) << $past(shift_count_i))
	) else $error("double shift left wrong");

	a_shift_carry: assert property (
		enable_i && op_i inside {ssru_pkg::DOUBLE_LOGICAL_RIGHT_SHIFT, ssru_pkg::DOUBLE_LOGICAL_LEFT_SHIFT}
		|=> $stable(carry_flag_o)
	) else $error("logical shift touched carry");

	a_wrot_right: assert property (
		enable_i && op_i == ssru_pkg::WORD_ROTATE_RIGHT && shift_count_i == ssru_pkg::COUNT_ONE
		|=> dest_lo_o == {$past(source_value_lo_i[0]), $past(source_value_lo_i[15:1])}
		    && carry_flag_o == $past(source_value_lo_i[0]) && $stable(dest_hi_o)
	) else $error("word rotate right wrong");

	a_wrot_left: assert property (
		enable_i && op_i == ssru_pkg::WORD_ROTATE_LEFT && shift_count_i == ssru_pkg::COUNT_ONE
		|=> dest_lo_o == {$past(source_value_lo_i[14:0]), $past(source_value_lo_i[15])}
		    && carry_flag_o == $past(source_value_lo_i[15])
	) else $error("word rotate left wrong");

	a_drot_one: assert property (
		enable_i && op_i == ssru_pkg::DOUBLE_ROTATE_LEFT && shift_count_i == ssru_pkg::COUNT_ONE
		|=> {dest_hi_o, dest_lo_o} == {$past(src_dword[30:0]), $past(source_value_hi_i[15])}
		    && carry_flag_o == $past(source_value_hi_i[15])
	) else $error("double rotate left by one wrong");

	a_wshift_keep: assert property (
		enable_i && op_i inside {ssru_pkg::WORD_LOGICAL_RIGHT_SHIFT, ssru_pkg::WORD_LOGICAL_LEFT_SHIFT}
		|=> $stable(carry_flag_o) && $stable(dest_hi_o)
	) else $error("word shift touched carry or high word");

	a_word_wide: assert property (
		enable_i && op_i inside {ssru_pkg::WORD_LOGICAL_RIGHT_SHIFT, ssru_pkg::WORD_LOGICAL_LEFT_SHIFT}
		&& shift_count_i >= ssru_pkg::WORD_MOD
		|=> dest_lo_o == 16'h0000
	) else $error("wide word shift not zero");

	a_dword_wide: assert property (
		enable_i && op_i inside {ssru_pkg::DOUBLE_LOGICAL_RIGHT_SHIFT, ssru_pkg::DOUBLE_LOGICAL_LEFT_SHIFT}
		&& shift_count_i >= ssru_pkg::DWORD_MOD
		|=> {dest_hi_o, dest_lo_o} == 32'h0000_0000
	) else $error("wide double shift not zero");

	// a zero count on a plain rotate passes the operand and leaves the carry alone
	a_rot_zero: assert property (
		enable_i && op_i inside {ssru_pkg::WORD_ROTATE_RIGHT, ssru_pkg::WORD_ROTATE_LEFT}
		&& shift_count_i == 16'h0000
		|=> dest_lo_o == $past(source_value_lo_i) && $stable(carry_flag_o)
	) else $error("zero-count rotate changed carry");

	a_unused_hold: assert property (
		enable_i && op_i > ssru_pkg::DOUBLE_LOGICAL_LEFT_SHIFT
		|=> $stable(dest_lo_o) && $stable(dest_hi_o) && $stable(carry_flag_o)
	) else $error("unused code changed state");

endmodule

// file: sim/shift_rotate_unit_tb.sv
`timescale 1ns/1ps

module shift_rotate_unit_tb;

	// ==========================================================
	// stimulus and observed signals
	logic               sys_clk_i         = 1'b0;
	logic               rstn_i            = 1'b0;
	logic               enable_i          = 1'b0;
	ssru_pkg::ssru_op_e op_i              = ssru_pkg::WORD_ROTATE_RIGHT;
	logic [15:0]        source_value_lo_i = 16'h0000;
	logic [15:0]        source_value_hi_i = 16'h0000;
	logic [15:0]        shift_count_i     = 16'h0000;
	logic [15:0]        dest_lo_o;
	logic [15:0]        dest_hi_o;
	logic               carry_flag_o;
	logic               done_o;
	int                 fails             = 0;
	int                 comparisons       = 0;
	// expected state: carry, high word, low word
	logic [32:0]        st                = 33'h0;
	logic               exp_done          = 1'b0;

	ssru_top dut (
		.sys_clk_i         (sys_clk_i),
		.rstn_i            (rstn_i),
		.enable_i          (enable_i),
		.op_i              (op_i),
		.source_value_lo_i (source_value_lo_i),
		.source_value_hi_i (source_value_hi_i),
		.shift_count_i     (shift_count_i),
		.dest_lo_o         (dest_lo_o),
		.dest_hi_o         (dest_hi_o),
		.carry_flag_o      (carry_flag_o),
		.done_o            (done_o)
	);

	always #5 sys_clk_i = ~sys_clk_i;

	// ==========================================================
	// reference model, rotates bit-serial so they share nothing with a barrel rotator
	function automatic logic [32:0] model(logic [3:0] op, logic [31:0] s, logic [15:0] n, logic [32:0] p);
		logic [32:0] v;
		logic [32:0] m;
		logic        c;
		int          w;
		c = p[32];
		if (op > 4'hb) return p;
		v = {1'b0, (op[3] ? op[1] : op[2]) ? s : {16'h0000, s[15:0]}};
		if (op[3]) begin
			w = op[1] ? 32 : 16;
			m = {33{1'b1}} >> (33 - w);
			v = (n >= w) ? 33'h0 : (op[0] ? (v << n) : (v >> n));
			v = v & m;
			return op[1] ? {c, v[31:0]} : {c, p[31:16], v[15:0]};
		end
		w = (op[2] ? 32 : 16) + (op[1] ? 1 : 0);
		m = {33{1'b1}} >> (33 - w);
		v = v | (op[1] ? ({32'h0, c} << (w - 1)) : 33'h0);
		for (int i = 0; i < n % w; i++) begin
			if (op[0]) begin
				v = ((v << 1) | (v >> (w - 1))) & m;
			end else begin
				v = ((v >> 1) | (v << (w - 1))) & m;
			end
		end
		if (op[1]) c = v[w - 1];
		else if (n != 0) c = op[0] ? v[0] : v[w - 1];
		return op[2] ? {c, v[31:0]} : {c, p[31:16], v[15:0]};
	endfunction

	// ==========================================================
	// compares and run control
	task automatic chk_val(logic [31:0] got, logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(logic got, logic exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		if (fails == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// called at a rising edge: inputs launched now are taken at the next edge, and the
	// falling edge between shows what the previous call left, so calls run back to back
	task automatic step(logic en, logic [3:0] op, logic [31:0] s, logic [15:0] n);
		enable_i          <= en;
		op_i              <= ssru_pkg::ssru_op_e'(op);
		source_value_lo_i <= s[15:0];
		source_value_hi_i <= s[31:16];
		shift_count_i     <= n;
		@(negedge sys_clk_i);
		chk_val({dest_hi_o, dest_lo_o}, st[31:0]);
		chk_bit(carry_flag_o, st[32]);
		chk_bit(done_o, exp_done);
		if (en) begin
			st = model(op, s, n, st);
		end
		exp_done = en;
		@(posedge sys_clk_i);
	endtask

	// reset held five cycles, then all outputs at their reset values; returns at an edge
	task automatic do_reset();
		rstn_i   <= 1'b0;
		enable_i <= 1'b0;
		repeat (5) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		@(negedge sys_clk_i);
		st       = {ssru_pkg::CARRY_RST, ssru_pkg::DEST_RST, ssru_pkg::DEST_RST};
		exp_done = ssru_pkg::DONE_RST;
		chk_val({dest_hi_o, dest_lo_o}, st[31:0]);
		chk_bit(carry_flag_o, st[32]);
		chk_bit(done_o, exp_done);
		@(posedge sys_clk_i);
	endtask

	// ==========================================================
	// scenarios
	// every code once, back to back, so each carry feeds the next op
	task automatic t_all_codes();
		logic [31:0] src [12] = '{32'h5a5acd95, 32'h5a5acd95, 32'h1234cd95, 32'hffffcd95,
			32'hb3989cac, 32'hb3989cac, 32'hb3989cac, 32'hb3989cac,
			32'h00017adc, 32'h80007adc, 32'h73989cac, 32'h73989cac};
		logic [15:0] cnt [12] = '{16'h0003, 16'h000f, 16'h0005, 16'h0010, 16'h0007, 16'h001e,
			16'h000b, 16'h0019, 16'h0005, 16'h0007, 16'h000a, 16'h000f};
		for (int i = 0; i < 12; i++) begin
			step(1'b1, 4'(i), src[i], cnt[i]);
		end
		step(1'b0, 4'h0, 32'h00000000, 16'h0000);
	endtask

	// one-bit moves on the codes whose one-bit checks would otherwise never start
	task automatic t_single_bit();
		step(1'b1, 4'h0, 32'h0000cd95, 16'h0001);
		step(1'b1, 4'h1, 32'h0000cd95, 16'h0001);
		step(1'b1, 4'h3, 32'h00004d95, 16'h0001);
		step(1'b1, 4'h4, 32'hb3989cac, 16'h0001);
		step(1'b1, 4'h5, 32'hb3989cac, 16'h0001);
		step(1'b1, 4'h6, 32'hb3989cad, 16'h0001);
		step(1'b0, 4'h6, 32'h00000000, 16'h0000);
	endtask

	// idle cycles with live-looking inputs must change nothing
	task automatic t_hold();
		step(1'b1, 4'h7, 32'hdead0001, 16'h0001);
		step(1'b0, 4'h0, 32'h12345678, 16'h0003);
		step(1'b0, 4'ha, 32'hffffffff, 16'h0001);
	endtask

	// width boundaries of counts, carry left alone by shifts
	task automatic t_bounds();
		step(1'b1, 4'h2, 32'h00000001, 16'h0001);
		step(1'b1, 4'h8, 32'h0000ffff, 16'h000f);
		step(1'b1, 4'h8, 32'h0000ffff, 16'h0010);
		step(1'b1, 4'h9, 32'h0000ffff, 16'h0010);
		step(1'b1, 4'ha, 32'hffffffff, 16'h001f);
		step(1'b1, 4'hb, 32'hffffffff, 16'h0020);
		step(1'b1, 4'hb, 32'hffffffff, 16'h0000);
		step(1'b1, 4'h0, 32'h00008000, 16'h0000);
		step(1'b1, 4'h3, 32'h0000a5a5, 16'h0011);
		step(1'b1, 4'h6, 32'h80000001, 16'h0021);
		step(1'b1, 4'h5, 32'h80000001, 16'h001f);
		step(1'b0, 4'h0, 32'h00000000, 16'h0000);
	endtask

	// unused codes only pulse the completion marker
	task automatic t_unused_codes();
		step(1'b1, 4'hc, 32'hffffffff, 16'h0001);
		step(1'b1, 4'hf, 32'h00000000, 16'h0005);
		step(1'b0, 4'h0, 32'h00000000, 16'h0000);
	endtask

	// reset in mid-run clears a non-zero state, and the first operation after it lands
	task automatic t_mid_reset();
		step(1'b1, 4'h7, 32'hffffffff, 16'h0001);
		step(1'b0, 4'h0, 32'h00000000, 16'h0000);
		do_reset();
		step(1'b1, 4'h0, 32'h0000cd95, 16'h0003);
		step(1'b0, 4'h0, 32'h00000000, 16'h0000);
	endtask

	initial begin
		do_reset();
		t_all_codes();
		t_single_bit();
		t_hold();
		t_bounds();
		t_unused_codes();
		t_mid_reset();
		end_of_test();
	end

	// the whole run needs well under a hundred cycles
	initial begin
		#20000;
		fails++;
		end_of_test();
	end

endmodule
